// file: rtl/cnm_clock_network.sv
// Clock network top: dynamic global muxes, gated global lines, one
// core-region local network, cell enables and interface-region clocks.
// Assumes all sources are levels synchronous to clock; static mux outputs
// arrive already chosen by configuration.
`timescale 1ns/1ps
module cnm_clock_network
	import cnm_pkg::*;
#(
	parameter int N_IN = DYN_INPUTS,
	parameter int SW = DYN_SEL_W,
	parameter bit TOP_BOTTOM = 1'b0
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Dynamic mux sources and control
	input wire logic [NUM_DYN_MUX-1:0][N_IN-1:0] dynSrc,
	input wire logic [NUM_DYN_MUX-1:0][SW-1:0] dynSel,
	input wire logic [NUM_DYN_MUX-1:0] dynEn,
	output logic [NUM_DYN_MUX-1:0] dynBusy,
	output logic [NUM_DYN_MUX-1:0][SW-1:0] dynActive,
	// Static sources and global line enables
	input wire logic [STATIC_LINES-1:0] staticSrc,
	input wire logic [GLOBAL_LINES-1:0] lineEn,
	output logic [GLOBAL_LINES-1:0] globalLine,
	// Local network of one core region
	input wire logic [REMOTE_LINES-1:0] remoteFabric,
	input wire logic [REGIONAL_TB-1:0] regional,
	input wire logic [LOCAL_SLOTS-1:0][POOL_W-1:0] localSel,
	input wire logic [LOCAL_SLOTS-1:0] localFabricUse,
	input wire logic [LOCAL_SLOTS-1:0] localFabricClk,
	output logic [LOCAL_SLOTS-1:0] localNet,
	// Logic cell clock enable
	input wire logic [ROW_W-1:0] cellRow,
	input wire logic cellCeFabric,
	output logic cellCe,
	output logic cellUpperNet,
	// Top and bottom interface region
	input wire logic [IF_TB_GLOBAL-1:0][GLB_W-1:0] ifTbSel,
	input wire logic [IF_TB_FABRIC-1:0] ifTbFabric,
	output logic [IF_TB_CLOCKS-1:0] ifTbClk,
	// Left and right interface region
	input wire logic [IF_LR_CLOCKS-1:0][LR_W-1:0] ifLrSel,
	input wire logic [IF_LR_FABRIC-1:0] ifLrFabric,
	output logic [IF_LR_CLOCKS-1:0] ifLrClk
);
	// ****************************************
	// Constants local to this module
	// ****************************************
	localparam int REG_COUNT = TOP_BOTTOM ? REGIONAL_TB : REGIONAL_CORE;
	localparam int REMOTE_BASE = GLOBAL_LINES;
	localparam int REG_BASE = GLOBAL_LINES + REMOTE_LINES;
	localparam int LR_REG_BASE = GLOBAL_LINES;
	localparam int LR_FAB_BASE = GLOBAL_LINES + REGIONAL_TB;
	localparam logic [ROW_W-1:0] HALF_ROW = ROW_W'(LOCAL_ROWS);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [GLOBAL_LINES-1:0] gate;
		logic [GLOBAL_LINES-1:0] line;
		logic [LOCAL_SLOTS-1:0] local_;
		logic cellCe;
		logic cellUpper;
		logic [IF_TB_CLOCKS-1:0] tb;
		logic [IF_LR_CLOCKS-1:0] lr;
	} cnm_net_st_t;

	cnm_net_st_t s_q, s_d;

	// Ungated sources of every global line
	logic [GLOBAL_LINES-1:0] lineSrc;
	// Regional lines this region may actually see
	logic [REGIONAL_TB-1:0] regVisible;
	// Pool seen by the local network: global, remote fabric, regional
	logic [POOL_SIZE-1:0] pool;
	// Pool seen by side interface regions: global, regional, fabric
	logic [LR_POOL-1:0] lrPool;

	// ****************************************
	// Functions
	// ****************************************
	// Pick one pool line; an index past the pool reads low
	function automatic logic pickPool(input logic [POOL_SIZE-1:0] p,
		input logic [POOL_W-1:0] idx);
		logic r;
		r = 1'b0;
		if (int'(idx) < POOL_SIZE) begin
			r = p[idx];
		end
		return r;
	endfunction

	// Pick a side-region source; fabric only for the first slots
	function automatic logic pickSide(input logic [LR_POOL-1:0] p,
		input logic [LR_W-1:0] idx, input int slot);
		logic r;
		r = 1'b0;
		if (int'(idx) < LR_FAB_BASE) begin
			r = p[idx];
		end else if (int'(idx) < LR_POOL && slot < IF_LR_FABRIC) begin
			r = p[idx];
		end
		return r;
	endfunction

	// Which 40-row local network a cell row belongs to
	function automatic logic upperHalf(input logic [ROW_W-1:0] row);
		return row >= HALF_ROW;
	endfunction

	// ****************************************
	// Dynamic global muxes
	// ****************************************
	// Two muxes per side feed the first eight global lines
	genvar gm;
	generate
		for (gm = 0; gm < NUM_DYN_MUX; gm++) begin : g_dyn
			cnm_mux_if #(.N(N_IN), .SW(SW)) muxLink ();
			assign muxLink.srcClk = dynSrc[gm];
			assign muxLink.sel = dynSel[gm];
			assign muxLink.muxEn = dynEn[gm];
			assign lineSrc[gm] = muxLink.clkOut;
			assign dynBusy[gm] = muxLink.busy;
			assign dynActive[gm] = muxLink.activeSel;
			// The switch assumes old and new inputs keep toggling
			cnm_dyn_mux #(.N(N_IN), .SW(SW)) u_mux (
				.clock(clock),
				.rst_n(rst_n),
				.ce(ce),
				.link(muxLink.mux)
			);
		end
	endgenerate

	// Remaining lines come from the fixed static muxes
	assign lineSrc[GLOBAL_LINES-1:NUM_DYN_MUX] = staticSrc;

	// ****************************************
	// Source pools
	// ****************************************
	// Regional lines beyond this region's share are held low
	genvar gr;
	generate
		for (gr = 0; gr < REGIONAL_TB; gr++) begin : g_reg
			assign regVisible[gr] = (gr < REG_COUNT) ? regional[gr] : 1'b0;
		end
	endgenerate

	// Index ranges of each pool follow the base constants, so a
	// resized source group cannot silently shift its neighbours
	assign pool[REMOTE_BASE-1:0] = s_q.line;
	assign pool[REG_BASE-1:REMOTE_BASE] = remoteFabric;
	assign pool[POOL_SIZE-1:REG_BASE] = regVisible;
	assign lrPool[LR_REG_BASE-1:0] = s_q.line;
	assign lrPool[LR_FAB_BASE-1:LR_REG_BASE] = regVisible;
	assign lrPool[LR_POOL-1:LR_FAB_BASE] = ifLrFabric;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		// Line enables change only while the line's source is low, so the
		// tree never sees a shortened pulse; a late enable waits a phase
		for (int i = 0; i < GLOBAL_LINES; i++) begin
			if (!lineSrc[i]) begin
				s_d.gate[i] = lineEn[i];
			end
			s_d.line[i] = lineSrc[i] & s_q.gate[i];
		end
		// Local slots: fabric override or a pooled line
		for (int k = 0; k < LOCAL_SLOTS; k++) begin
			if (localFabricUse[k]) begin
				s_d.local_[k] = localFabricClk[k];
			end else begin
				s_d.local_[k] = pickPool(pool, localSel[k]);
			end
		end
		// Cell enable straight from fabric, per cell
		s_d.cellCe = cellCeFabric;
		s_d.cellUpper = upperHalf(cellRow);
		// Top/bottom interface: 14 global picks then 2 fabric
		for (int t = 0; t < IF_TB_GLOBAL; t++) begin
			s_d.tb[t] = s_q.line[ifTbSel[t]];
		end
		for (int f = 0; f < IF_TB_FABRIC; f++) begin
			s_d.tb[IF_TB_GLOBAL+f] = ifTbFabric[f];
		end
		// Left/right interface: four clocks, fabric only on two
		for (int l = 0; l < IF_LR_CLOCKS; l++) begin
			s_d.lr[l] = pickSide(lrPool, ifLrSel[l], l);
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Reset stands for configuration done: all lines off until enabled
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign globalLine = s_q.line;
	assign localNet = s_q.local_;
	assign cellCe = s_q.cellCe;
	assign cellUpperNet = s_q.cellUpper;
	assign ifTbClk = s_q.tb;
	assign ifLrClk = s_q.lr;

endmodule

// file: rtl/cnm_dyn_mux.sv
// One run-time switchable global clock mux with glitch-free handover.
// Assumes the caller keeps both old and new inputs toggling while busy.
`timescale 1ns/1ps
module cnm_dyn_mux
	import cnm_pkg::*;
#(
	parameter int N = DYN_INPUTS,
	parameter int SW = DYN_SEL_W
) (
	// Clock and control
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Link to the network top
	cnm_mux_if.mux link
);
	typedef struct packed {
		cnm_mux_state_t state;
		logic [SW-1:0] curSel;
		logic [SW-1:0] tgtSel;
		logic seenHigh;
		logic outClk;
	} cnm_mux_st_t;

	cnm_mux_st_t s_q, s_d;
	logic oldLvl, newLvl;

	assign oldLvl = link.srcClk[s_q.curSel];
	assign newLvl = link.srcClk[s_q.tgtSel];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		if (!link.muxEn) begin
			// Output idle, so the input can change at once
			s_d.outClk = 1'b0;
			s_d.curSel = link.sel;
			s_d.tgtSel = link.sel;
			s_d.state = MUX_RUN;
		end else begin
			unique case (s_q.state)
				MUX_RUN: begin
					s_d.outClk = oldLvl;
					if (link.sel != s_q.curSel) begin
						s_d.tgtSel = link.sel;
						s_d.state = MUX_DRAIN;
					end
				end
				MUX_DRAIN: begin
					// Let the high phase finish, never cut it short
					s_d.outClk = oldLvl;
					if (!oldLvl) begin
						s_d.seenHigh = 1'b0;
						s_d.state = MUX_ARM;
					end
				end
				MUX_ARM: begin
					// Held low until the new source shows a full high then low
					s_d.outClk = 1'b0;
					if (link.sel != s_q.tgtSel) begin
						s_d.tgtSel = link.sel;
						s_d.seenHigh = 1'b0;
					end else if (newLvl) begin
						s_d.seenHigh = 1'b1;
					end else if (s_q.seenHigh) begin
						s_d.curSel = s_q.tgtSel;
						s_d.state = MUX_RUN;
					end
				end
			endcase
		end
	end

	// Register, frozen while ce is low
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= '{state: MUX_RUN, curSel: DEFAULT_INPUT, tgtSel: DEFAULT_INPUT,
				seenHigh: 1'b0, outClk: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign link.clkOut = s_q.outClk;
	assign link.busy = (s_q.state != MUX_RUN);
	assign link.activeSel = s_q.curSel;
endmodule

// file: rtl/cnm_mux_if.sv
// Link between the clock network top and one dynamic global mux.
// Assumes one system clock; sources are sampled levels.
`timescale 1ns/1ps
interface cnm_mux_if #(parameter int N = 4, parameter int SW = 2);
	logic [N-1:0] srcClk;
	logic [SW-1:0] sel;
	logic muxEn;
	logic clkOut;
	logic busy;
	logic [SW-1:0] activeSel;
	modport ctrl (output srcClk, sel, muxEn, input clkOut, busy, activeSel);
	modport mux (input srcClk, sel, muxEn, output clkOut, busy, activeSel);
endinterface

// file: rtl/cnm_pkg.sv
// Constants and types for the clock network: dynamic global muxes,
// global line gating, local and interface-region clock selection.
// Assumes every clock source is sampled as a level on the one system clock.
// Contract
// - Eight dynamic global muxes, two per side
// - Select bus picks the active mux input
// - Input zero active after configuration
// - Local network takes 16 of pooled lines
// - Regional share eight top/bottom, otherwise four
// - Local fabric may drive local network
// - Fabric drives each cell clock enable
// - 80-row region, two 40-row local networks
// - Top/bottom interface: 14 global, 2 fabric
// - Left/right interface: four clocks, two fabric
// - Per-line glitch-free dynamic enable
// - Thirty-two balanced global lines
package cnm_pkg;
	// ****************************************
	// Global network and dynamic muxes
	// ****************************************
	localparam int NUM_SIDES = 4;
	localparam int MUXES_PER_SIDE = 2;
	localparam int NUM_DYN_MUX = NUM_SIDES * MUXES_PER_SIDE;
	localparam int DYN_INPUTS = 4;
	localparam int DYN_SEL_W = $clog2(DYN_INPUTS);
	localparam logic [DYN_SEL_W-1:0] DEFAULT_INPUT = 2'h0;
	localparam int GLOBAL_LINES = 32;
	localparam int GLB_W = $clog2(GLOBAL_LINES);
	localparam int STATIC_LINES = GLOBAL_LINES - NUM_DYN_MUX;
	// ****************************************
	// Local network sizes
	// ****************************************
	localparam int LOCAL_SLOTS = 16;
	localparam int REMOTE_LINES = 16;
	localparam int REGIONAL_TB = 8;
	localparam int REGIONAL_CORE = 4;
	localparam int POOL_SIZE = GLOBAL_LINES + REMOTE_LINES + REGIONAL_TB;
	localparam int POOL_W = $clog2(POOL_SIZE);
	localparam int REGION_ROWS = 80;
	localparam int LOCAL_ROWS = 40;
	localparam int ROW_W = $clog2(REGION_ROWS);
	// ****************************************
	// Interface regions
	// ****************************************
	localparam int IF_TB_GLOBAL = 14;
	localparam int IF_TB_FABRIC = 2;
	localparam int IF_TB_CLOCKS = IF_TB_GLOBAL + IF_TB_FABRIC;
	localparam int IF_LR_CLOCKS = 4;
	localparam int IF_LR_FABRIC = 2;
	localparam int LR_POOL = GLOBAL_LINES + REGIONAL_TB + IF_LR_FABRIC;
	localparam int LR_W = $clog2(LR_POOL);
	// Dynamic mux handover phases
	typedef enum logic [1:0] {MUX_RUN, MUX_DRAIN, MUX_ARM} cnm_mux_state_t;
endpackage

// file: test/cnm_clock_network_props.sv
// Checker for the clock network top, bound by its ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module cnm_clock_network_props
	import cnm_pkg::*;
#(
	parameter int N_IN = DYN_INPUTS,
	parameter int SW = DYN_SEL_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Dynamic muxes
	input wire logic [NUM_DYN_MUX-1:0][SW-1:0] dynSel,
	input wire logic [NUM_DYN_MUX-1:0] dynEn,
	input wire logic [NUM_DYN_MUX-1:0] dynBusy,
	input wire logic [NUM_DYN_MUX-1:0][SW-1:0] dynActive,
	// Global lines
	input wire logic [STATIC_LINES-1:0] staticSrc,
	input wire logic [GLOBAL_LINES-1:0] lineEn,
	input wire logic [GLOBAL_LINES-1:0] globalLine,
	// Cells and interface
	input wire logic [ROW_W-1:0] cellRow,
	input wire logic cellCeFabric,
	input wire logic cellCe,
	input wire logic cellUpperNet,
	input wire logic [IF_TB_FABRIC-1:0] ifTbFabric,
	input wire logic [IF_TB_CLOCKS-1:0] ifTbClk
);
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clock); endclocking
	a_reset_default: assert property ((!rst_n && ce) |=> (dynActive == '0 && dynBusy == '0))
		else $error("mux not at input zero after reset");
	a_busy_on_request: assert property (disable iff (!rst_n)
		(ce && dynEn[0] && !dynBusy[0] && dynSel[0] != dynActive[0]) |=> dynBusy[0])
		else $error("switch request not taken");
	a_active_only_handover: assert property (disable iff (!rst_n)
		$changed(dynActive[0]) |-> (!$past(rst_n) || $past(dynBusy[0]) || !$past(dynEn[0])))
		else $error("active input changed without handover");
	a_line_follows_src: assert property (disable iff (!rst_n)
		(ce && $past(ce) && globalLine[8]) |-> $past(staticSrc[0]))
		else $error("global line high without source");
	a_line_gate_off: assert property (disable iff (!rst_n)
		(ce && !staticSrc[0] && !lineEn[8]) ##1 (ce && !lineEn[8]) [*2] |=> !globalLine[8])
		else $error("disabled global line still toggles");
	a_cell_ce_copy: assert property (disable iff (!rst_n)
		ce |=> cellCe == $past(cellCeFabric))
		else $error("cell enable not from fabric");
	a_upper_half: assert property (disable iff (!rst_n)
		ce |=> cellUpperNet == ($past(cellRow) >= LOCAL_ROWS))
		else $error("cell row in wrong local network");
	a_tb_fabric_pass: assert property (disable iff (!rst_n)
		ce |=> ifTbClk[15:14] == $past(ifTbFabric))
		else $error("interface fabric clocks wrong");
	// Main scenarios reached
	cover property ($fell(dynBusy[0]));
	cover property (globalLine[8]);
	cover property (globalLine[0]);
	cover property (cellUpperNet);
endmodule
bind cnm_clock_network cnm_clock_network_props #(.N_IN(N_IN), .SW(SW)) props (.clock(clock), .rst_n(rst_n),
	.ce(ce), .dynSel(dynSel), .dynEn(dynEn), .dynBusy(dynBusy), .dynActive(dynActive), .staticSrc(staticSrc),
	.lineEn(lineEn), .globalLine(globalLine), .cellRow(cellRow), .cellCeFabric(cellCeFabric), .cellCe(cellCe),
	.cellUpperNet(cellUpperNet), .ifTbFabric(ifTbFabric), .ifTbClk(ifTbClk));

// file: test/cnm_clock_network_tb.sv
// Self-checking bench for the clock network top.
// Assumes the source model drives the mux inputs.
`timescale 1ns/1ps
module cnm_clock_network_tb
	import cnm_pkg::*;
;
	typedef struct packed {logic [ROW_W-1:0] row; logic ceFab; logic upper;} cnm_row_t;
	logic clock, rst_n, ce, cellCeFabric, cellCe, cellUpperNet;
	logic [NUM_DYN_MUX-1:0][DYN_INPUTS-1:0] dynSrc;
	logic [NUM_DYN_MUX-1:0][DYN_SEL_W-1:0] dynSel, dynActive;
	logic [NUM_DYN_MUX-1:0] dynEn, dynBusy;
	logic [STATIC_LINES-1:0] staticSrc;
	logic [GLOBAL_LINES-1:0] lineEn, globalLine;
	logic [REMOTE_LINES-1:0] remoteFabric;
	logic [REGIONAL_TB-1:0] regional;
	logic [LOCAL_SLOTS-1:0][POOL_W-1:0] localSel;
	logic [LOCAL_SLOTS-1:0] localFabricUse, localFabricClk, localNet;
	logic [ROW_W-1:0] cellRow;
	logic [IF_TB_GLOBAL-1:0][GLB_W-1:0] ifTbSel;
	logic [IF_TB_FABRIC-1:0] ifTbFabric;
	logic [IF_TB_CLOCKS-1:0] ifTbClk;
	logic [IF_LR_CLOCKS-1:0][LR_W-1:0] ifLrSel;
	logic [IF_LR_FABRIC-1:0] ifLrFabric;
	logic [IF_LR_CLOCKS-1:0] ifLrClk;
	int n_fail = 0;
	int samples_checked = 0;
	logic seen;
	cnm_row_t rows [4] = '{'{7'h00, 1'b1, 1'b0}, '{7'h27, 1'b0, 1'b0}, '{7'h28, 1'b1, 1'b1}, '{7'h4F, 1'b0, 1'b1}};
	cnm_clock_network dut (.clock(clock), .rst_n(rst_n), .ce(ce), .dynSrc(dynSrc), .dynSel(dynSel),
		.dynEn(dynEn), .dynBusy(dynBusy), .dynActive(dynActive), .staticSrc(staticSrc), .lineEn(lineEn),
		.globalLine(globalLine), .remoteFabric(remoteFabric), .regional(regional), .localSel(localSel),
		.localFabricUse(localFabricUse), .localFabricClk(localFabricClk), .localNet(localNet),
		.cellRow(cellRow), .cellCeFabric(cellCeFabric), .cellCe(cellCe), .cellUpperNet(cellUpperNet),
		.ifTbSel(ifTbSel), .ifTbFabric(ifTbFabric), .ifTbClk(ifTbClk), .ifLrSel(ifLrSel),
		.ifLrFabric(ifLrFabric), .ifLrClk(ifLrClk));
	cnm_src_model srcs (.clock(clock), .dynSrc(dynSrc));
	// ****
	// Helpers
	// ****
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Inputs move 1 ns after the edge, never on it
	task automatic tick(int n = 1);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Bounded wait: a stuck handover ends the run
	task automatic switchAll(logic [DYN_SEL_W-1:0] s);
		dynSel = {NUM_DYN_MUX{s}};
		tick(2);
		chk("busy", 32'hFF, 32'(dynBusy));
		for (int i = 0; i <= 200; i++) begin
			if (dynBusy === '0) break;
			if (i == 200) begin
				n_fail++;
				$display("mismatch handover expected 0 seen %0h", dynBusy);
				final_report();
			end
			tick();
		end
		for (int m = 0; m < NUM_DYN_MUX; m++) chk("active", 32'(s), 32'(dynActive[m]));
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		{rst_n, dynSel, dynEn, staticSrc, lineEn, remoteFabric, regional, localSel} = '0;
		{localFabricUse, localFabricClk, cellRow, cellCeFabric, ifTbSel, ifTbFabric, ifLrSel, ifLrFabric} = '0;
		ce = 1'b1;
		tick(2);
		chk("reset active", 32'h0, 32'(dynActive));
		rst_n = 1'b1;
		foreach (rows[i]) begin
			cellRow = rows[i].row;
			cellCeFabric = rows[i].ceFab;
			tick();
			chk("upper", 32'(rows[i].upper), 32'(cellUpperNet));
			chk("cell ce", 32'(rows[i].ceFab), 32'(cellCe));
		end
		// Held enable stays frozen while ce is low
		ce = 1'b0;
		cellCeFabric = 1'b1;
		tick(2);
		chk("frozen ce", 32'h0, 32'(cellCe));
		ce = 1'b1;
		// Back-to-back switches on all eight muxes
		dynEn = '1;
		switchAll(2'h1);
		switchAll(2'h3);
		// Second reset returns every mux to input 0
		rst_n = 1'b0;
		tick();
		rst_n = 1'b1;
		chk("rerun active", 32'h0, 32'(dynActive));
		// Pool picks, masked regional, fabric override of an out-of-range select
		remoteFabric = 16'h0001;
		regional = 8'hFF;
		localSel[0] = 6'h20;
		localSel[1] = 6'h34;
		localSel[2] = 6'h30;
		localSel[3] = 6'h3F;
		localSel[4] = 6'h08;
		ifTbSel[0] = 5'h08;
		localFabricUse = 16'h0008;
		localFabricClk = 16'h0008;
		ifLrSel = {6'h24, 6'h29, 6'h29, 6'h28};
		ifLrFabric = 2'h3;
		ifTbFabric = 2'h2;
		tick();
		chk("local", 32'hD, 32'(localNet[3:0]));
		chk("lr", 32'h3, 32'(ifLrClk));
		chk("tb fabric", 32'h2, 32'(ifTbClk[15:14]));
		// Gate opens with the source low, ignores changes while high
		lineEn = '1;
		tick(2);
		staticSrc[0] = 1'b1;
		tick(2);
		lineEn[8] = 1'b0;
		tick(2);
		chk("line held", 32'h1, 32'(globalLine[8]));
		chk("tb global", 32'h1, 32'(ifTbClk[0]));
		chk("local global", 32'h1, 32'(localNet[4]));
		staticSrc[0] = 1'b0;
		tick(2);
		staticSrc[0] = 1'b1;
		tick(2);
		chk("line off", 32'h0, 32'(globalLine[8]));
		chk("tb global off", 32'h0, 32'(ifTbClk[0]));
		chk("local global off", 32'h0, 32'(localNet[4]));
		// Dynamic mux 0 must reach global line 0 once the line is enabled
		seen = 1'b0;
		for (int i = 0; i < 40; i++) begin
			if (globalLine[0] === 1'b1) seen = 1'b1;
			tick();
		end
		chk("mux line", 32'h1, 32'(seen));
		final_report();
	end
endmodule

// file: test/cnm_src_model.sv
// Far-side clock sources feeding every dynamic mux input.
// Assumes the bench clock; input k toggles every k+1 cycles.
`timescale 1ns/1ps
module cnm_src_model
	import cnm_pkg::*;
(
	// Clock
	input wire logic clock,
	// Mux sources
	output logic [NUM_DYN_MUX-1:0][DYN_INPUTS-1:0] dynSrc
);
	int cnt = 0;
	// Input 0 and all targets keep toggling, else a switch never ends
	initial begin
		dynSrc = '0;
		forever begin
			@(posedge clock);
			#1;
			cnt++;
			for (int m = 0; m < NUM_DYN_MUX; m++) begin
				for (int k = 0; k < DYN_INPUTS; k++) begin
					dynSrc[m][k] = 1'((cnt / (k + 1)) % 2);
				end
			end
		end
	end
endmodule
